// [core/input_fault_diag_status.sv]
// Overview of operation
// RULE_01: Bit 7 shows channel-2 open inputs
// RULE_02: Bit 6 shows channel-2 pins shorted together
// RULE_03: Bits 5/4 show positive/negative shorted to ground
// RULE_04: Bits 3/2 show shorts to mic-bias supply
// RULE_05: Bits 1/0 show shorts to battery sense
// RULE_06: Channel-2 live register read-only, resets to zero
// RULE_07: Over-voltage bits 7..4 for four input pins
// RULE_08: Reserved bits read zero, software writes zero
// RULE_09: Event bits 7/6 monitor upper/lower threshold
// RULE_10: Event bits 5/4 voice power up/down
// RULE_11: Event bits 3..0 mic-bias fault kinds
// RULE_12: Config bits 7/6 enable channel scans
// RULE_13: Config bit 5 includes single-ended negatives
// RULE_14: Config bit 4 includes AC-coupled channels
// RULE_15: Latched mic-bias bits self-clear, read-only
// RULE_16: Disabled channel live bits read zero
// RULE_17: Live reads side-effect free, bits follow sources
`timescale 1ns/1ps
`default_nettype none
module input_fault_diag_status (
  input wire logic clk, // Register clock, 100 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire diag_regs_pkg::reg_addr_t reg_addr, // Control port address
  input wire logic reg_wr, // Write strobe, one cycle
  input wire diag_regs_pkg::reg_byte_t reg_wdata, // Write data
  input wire logic reg_rd, // Read strobe, one cycle
  output logic [7:0] reg_rdata, // Read data, registered
  output logic reg_rd_valid, // Read data valid pulse
  input wire logic ch2_single_ended, // Channel 2 wired single-ended
  input wire logic ch2_ac_coupled, // Channel 2 AC-coupled
  input wire logic [7:0] ch2_fault_raw, // Channel-2 fault comparators
  input wire logic [3:0] ov_raw, // Over-voltage comparators
  input wire logic [7:0] aux_raw, // Monitor, detector, bias sources
  output logic ch1_scan_enable, // Scan channel 1 pins
  output logic ch2_scan_enable, // Scan channel 2 pins
  output logic include_single_ended_neg, // Scan single-ended negatives
  output logic include_ac_coupled // Scan AC-coupled channels
);
  import diag_regs_pkg::*;

  // Synchronised sources
  live_src_if src ();

  // Channel-2 live fault register
  reg_byte_t ch2_live_q;
  // Over-voltage live register
  reg_byte_t ov_live_q;
  // Monitor and bias event live register
  reg_byte_t event_live_q;
  // Latched mic-bias events
  reg_byte_t bias_latched_q;
  reg_byte_t bias_latched_d;
  // Scan configuration register
  reg_byte_t scan_cfg_q;
  // Read path
  reg_byte_t rdata_q;
  reg_byte_t rdata_d;
  logic rd_valid_q;
  // Channel-2 mask after scan selection
  reg_byte_t ch2_keep;
  // Channel-2 taken part in the scan
  logic ch2_scanned;
  // Negative pin of channel 2 taken part in the scan
  logic ch2_neg_scanned;
  // Latched register read this cycle
  logic latched_read;

  // Condition sampler
  live_sync u_sync (
    .clk(clk),
    .srst(srst),
    .ch2_fault_raw(ch2_fault_raw),
    .ov_raw(ov_raw),
    .aux_raw(aux_raw),
    .src(src)
  );

  // Decide which channel-2 fault bits the scan covers
  always_comb
  begin
    // Scan off or AC-coupled channel excluded drops the whole channel
    ch2_scanned = scan_cfg_q[CH2_SCAN_EN_BIT] // RULE_12 RULE_16
      && (!ch2_ac_coupled || scan_cfg_q[INCL_AC_BIT]); // RULE_14
    // Single-ended negative pin only when selected
    ch2_neg_scanned = !ch2_single_ended || scan_cfg_q[INCL_SE_NEG_BIT]; // RULE_13
    if (!ch2_scanned)
    begin
      // Whole channel out of the scan
      ch2_keep = 8'h00; // RULE_16
    end
    else if (!ch2_neg_scanned)
    begin
      // Negative-pin bits held clear
      ch2_keep = ~CH2_NEG_PIN_MASK; // RULE_13
    end
    else
    begin
      // Every fault kind reported
      ch2_keep = 8'hFF;
    end
  end

  // Channel-2 live fault register follows the scanned conditions
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      // No fault after reset
      ch2_live_q <= CH2_LIVE_RESET; // RULE_06
    end
    else
    begin
      // Bit 7 open, 6 shorted, 5..0 pin shorts, no latching
      ch2_live_q <= src.ch2 & ch2_keep; // RULE_01 RULE_02 RULE_03 RULE_04 RULE_05 RULE_17
    end
  end

  // Over-voltage live register, low nibble reserved
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      // No fault after reset
      ov_live_q <= OV_LIVE_RESET;
    end
    else
    begin
      // Upper nibble mirrors the comparators, lower reads zero
      ov_live_q <= {src.ov, 4'h0}; // RULE_07 RULE_08
    end
  end

  // Monitor, voice activity and mic-bias live register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      // No event after reset
      event_live_q <= EVENT_LIVE_RESET;
    end
    else
    begin
      // Plain mirror of the present conditions
      event_live_q <= src.aux; // RULE_09 RULE_10 RULE_11
    end
  end

  // Read of the latched register clears what it returns
  assign latched_read = reg_rd && (reg_addr == BIAS_LATCHED_OFFSET);

  // Latched mic-bias events: a new event wins over the clearing read
  always_comb
  begin
    bias_latched_d = bias_latched_q;
    if (latched_read)
    begin
      // Self-clear on read
      bias_latched_d = 8'h00; // RULE_15
    end
    // Catch present mic-bias faults
    bias_latched_d = bias_latched_d | (src.aux & BIAS_FAULT_MASK); // RULE_15
  end

  // Latched register storage
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      // Nothing caught after reset
      bias_latched_q <= BIAS_LATCHED_RESET;
    end
    else
    begin
      // Hold, set or clear
      bias_latched_q <= bias_latched_d;
    end
  end

  // Scan configuration register, only the upper nibble stores
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      // All scans off
      scan_cfg_q <= SCAN_CFG_RESET; // RULE_12
    end
    else if (reg_wr && (reg_addr == SCAN_CFG_OFFSET))
    begin
      // Reserved bits dropped so they read zero
      scan_cfg_q <= reg_wdata & SCAN_CFG_WRITABLE; // RULE_08 RULE_12
    end
  end

  // Read multiplexer; read-only and unmapped writes are ignored
  always_comb
  begin
    case (reg_addr)
      CH2_LIVE_OFFSET: rdata_d = ch2_live_q; // RULE_06
      OV_LIVE_OFFSET: rdata_d = ov_live_q;
      EVENT_LIVE_OFFSET: rdata_d = event_live_q;
      BIAS_LATCHED_OFFSET: rdata_d = bias_latched_q;
      SCAN_CFG_OFFSET: rdata_d = scan_cfg_q;
      default: rdata_d = UNMAPPED_READ;
    endcase
  end

  // Read data register, updates only on a read strobe
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      // Bus idle
      rdata_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      // Valid pulses one cycle after each strobe
      rd_valid_q <= reg_rd;
      if (reg_rd)
      begin
        // Capture without disturbing any live bit
        rdata_q <= rdata_d; // RULE_17
      end
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_q;
  assign reg_rd_valid = rd_valid_q;
  assign ch1_scan_enable = scan_cfg_q[CH1_SCAN_EN_BIT]; // RULE_12
  assign ch2_scan_enable = scan_cfg_q[CH2_SCAN_EN_BIT]; // RULE_12
  assign include_single_ended_neg = scan_cfg_q[INCL_SE_NEG_BIT]; // RULE_13
  assign include_ac_coupled = scan_cfg_q[INCL_AC_BIT]; // RULE_14

  // Checks on the register bank
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // Reset leaves the channel-2 register clear
  property p_ch2_reset;
    @(posedge clk) $fell(srst) |-> ((ch2_live_q == CH2_LIVE_RESET) && !rd_valid_q);
  endproperty
  a_ch2_reset: assert property (p_ch2_reset) else $error("ch2 live not clear after reset"); // RULE_06

  // Open bit tracks the scanned condition one cycle later
  property p_ch2_open;
    ch2_scanned |=> (ch2_live_q[7] == $past(src.ch2[7]));
  endproperty
  a_ch2_open: assert property (p_ch2_open) else $error("open bit wrong"); // RULE_01

  // Shorted bit tracks its condition
  property p_ch2_shorted;
    ch2_scanned |=> (ch2_live_q[6] == $past(src.ch2[6]));
  endproperty
  a_ch2_shorted: assert property (p_ch2_shorted) else $error("shorted bit wrong"); // RULE_02

  // Positive-pin ground, bias and battery shorts
  property p_ch2_pos_shorts;
    ch2_scanned |=> ({ch2_live_q[5], ch2_live_q[3], ch2_live_q[1]}
      == $past({src.ch2[5], src.ch2[3], src.ch2[1]}));
  endproperty
  a_ch2_pos_shorts: assert property (p_ch2_pos_shorts) else $error("positive pin short wrong"); // RULE_03

  // Negative-pin shorts follow only when that pin is scanned
  property p_ch2_neg_shorts;
    (ch2_scanned && ch2_neg_scanned) |=> ({ch2_live_q[4], ch2_live_q[2], ch2_live_q[0]}
      == $past({src.ch2[4], src.ch2[2], src.ch2[0]}));
  endproperty
  a_ch2_neg_shorts: assert property (p_ch2_neg_shorts) else $error("negative pin short wrong"); // RULE_05

  // Excluded single-ended negative pin never reports
  property p_se_neg_excluded;
    (ch2_single_ended && !scan_cfg_q[5]) |=> ((ch2_live_q & 8'h15) == 8'h00);
  endproperty
  a_se_neg_excluded: assert property (p_se_neg_excluded) else $error("excluded negative pin reported"); // RULE_13

  // AC-coupled channel excluded from diagnosis
  property p_ac_excluded;
    (ch2_ac_coupled && !scan_cfg_q[4]) |=> (ch2_live_q == 8'h00);
  endproperty
  a_ac_excluded: assert property (p_ac_excluded) else $error("AC-coupled channel reported"); // RULE_14

  // Disabled channel reads zero
  property p_ch2_disabled;
    !scan_cfg_q[6] |=> (ch2_live_q == 8'h00);
  endproperty
  a_ch2_disabled: assert property (p_ch2_disabled) else $error("disabled channel reported"); // RULE_16

  // Over-voltage nibble and reserved zeros
  property p_ov_live;
    1'b1 |=> (ov_live_q == {$past(src.ov), 4'h0});
  endproperty
  a_ov_live: assert property (p_ov_live) else $error("over-voltage register wrong"); // RULE_07

  // Event register mirrors all eight conditions
  property p_event_live;
    1'b1 |=> (event_live_q == $past(src.aux));
  endproperty
  a_event_live: assert property (p_event_live) else $error("event register wrong"); // RULE_11

  // Config write keeps the upper nibble, reserved bits stay zero
  property p_cfg_write;
    (reg_wr && reg_addr == 8'h46) |=> (scan_cfg_q == ($past(reg_wdata) & 8'hF0));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write wrong"); // RULE_12

  // Reserved config bits never read one
  property p_cfg_reserved;
    (scan_cfg_q[3:0] == 4'h0) && (ov_live_q[3:0] == 4'h0);
  endproperty
  a_cfg_reserved: assert property (p_cfg_reserved) else $error("reserved bit set"); // RULE_08

  // A read of the channel-2 register returns it and leaves it alone
  sequence s_ch2_read;
    reg_rd && (reg_addr == 8'h3F) && $stable(src.ch2);
  endsequence
  sequence s_ch2_answer;
    reg_rd_valid && (reg_rdata == $past(ch2_live_q));
  endsequence
  property p_ch2_read;
    s_ch2_read |=> s_ch2_answer;
  endproperty
  a_ch2_read: assert property (p_ch2_read) else $error("channel-2 read wrong"); // RULE_17

  // A latched read with no fault present clears the register
  property p_latched_clear;
    (latched_read && ((src.aux & 8'h0F) == 8'h00)) |=> (bias_latched_q == 8'h00);
  endproperty
  a_latched_clear: assert property (p_latched_clear) else $error("latched bits not cleared"); // RULE_15

  // A present mic-bias fault is always caught, even during a clear
  property p_latched_set;
    ((src.aux & 8'h0F) != 8'h00) |=> ((bias_latched_q & $past(src.aux & 8'h0F)) == $past(src.aux & 8'h0F));
  endproperty
  a_latched_set: assert property (p_latched_set) else $error("mic-bias event lost"); // RULE_15

  // Upper-threshold monitor bit never latches
  property p_monitor_follow;
    $fell(src.aux[7]) |=> !event_live_q[7];
  endproperty
  a_monitor_follow: assert property (p_monitor_follow) else $error("monitor bit latched"); // RULE_09
endmodule : input_fault_diag_status
`default_nettype wire

// [core/diag_regs_pkg.sv]
// Shared constants for the input fault diagnostic status block
package diag_regs_pkg;
  // Register data word
  typedef logic [7:0] reg_byte_t;
  // Register port address
  typedef logic [7:0] reg_addr_t;

  // Register offsets
  localparam reg_addr_t CH2_LIVE_OFFSET = 8'h3F;
  localparam reg_addr_t BIAS_LATCHED_OFFSET = 8'h41;
  localparam reg_addr_t OV_LIVE_OFFSET = 8'h42;
  localparam reg_addr_t EVENT_LIVE_OFFSET = 8'h43;
  localparam reg_addr_t SCAN_CFG_OFFSET = 8'h46;

  // Reset values
  localparam reg_byte_t CH2_LIVE_RESET = 8'h00;
  localparam reg_byte_t BIAS_LATCHED_RESET = 8'h00;
  localparam reg_byte_t OV_LIVE_RESET = 8'h00;
  localparam reg_byte_t EVENT_LIVE_RESET = 8'h00;
  localparam reg_byte_t SCAN_CFG_RESET = 8'h00;
  localparam reg_byte_t UNMAPPED_READ = 8'h00;

  // Channel-2 live fault field positions
  localparam int CH2_OPEN_BIT = 7;
  localparam int CH2_SHORTED_BIT = 6;
  localparam int CH2_POS_GND_BIT = 5;
  localparam int CH2_NEG_GND_BIT = 4;
  localparam int CH2_POS_BIAS_BIT = 3;
  localparam int CH2_NEG_BIAS_BIT = 2;
  localparam int CH2_POS_BAT_BIT = 1;
  localparam int CH2_NEG_BAT_BIT = 0;

  // Over-voltage live field: bits 7..4 hold the four pins, 3..0 reserved
  localparam int OV_FIELD_LSB = 4;
  localparam int OV_FIELD_WIDTH = 4;

  // Scan configuration field positions
  localparam int CH1_SCAN_EN_BIT = 7;
  localparam int CH2_SCAN_EN_BIT = 6;
  localparam int INCL_SE_NEG_BIT = 5;
  localparam int INCL_AC_BIT = 4;
  localparam reg_byte_t SCAN_CFG_WRITABLE = 8'hF0;

  // Mic-bias fault field inside the event registers
  localparam reg_byte_t BIAS_FAULT_MASK = 8'h0F;
  // Negative-pin bits of the channel-2 live register
  localparam reg_byte_t CH2_NEG_PIN_MASK = 8'h15;
endpackage : diag_regs_pkg

// [core/live_src_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Synchronised fault conditions handed from the sampler to the register bank
interface live_src_if;
  // Channel-2 DC fault conditions
  logic [7:0] ch2;
  // Over-voltage conditions, ch1 pos, ch1 neg, ch2 pos, ch2 neg
  logic [3:0] ov;
  // Monitor, voice activity and mic-bias conditions
  logic [7:0] aux;

  // Sampler side
  modport producer (output ch2, output ov, output aux);
  // Register bank side
  modport consumer (input ch2, input ov, input aux);
endinterface : live_src_if
`default_nettype wire

// [core/live_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for every analog fault condition
module live_sync (
  input wire logic clk, // Register clock
  input wire logic srst, // Synchronous reset
  input wire logic [7:0] ch2_fault_raw, // Channel-2 comparators
  input wire logic [3:0] ov_raw, // Over-voltage comparators
  input wire logic [7:0] aux_raw, // Monitor, detector, bias sources
  live_src_if.producer src // Synchronised conditions
);
  // All raw conditions side by side
  logic [19:0] raw_all;
  // First stage, read only by the second stage
  logic [19:0] meta_q;
  // Second stage, safe to use
  logic [19:0] sync_q;

  assign raw_all = {ch2_fault_raw, ov_raw, aux_raw};

  // One synchroniser pair per condition bit
  genvar gi;
  generate
    for (gi = 0; gi < 20; gi++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end
        else
        begin
          meta_q[gi] <= raw_all[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  // Split back into groups
  assign src.ch2 = sync_q[19:12];
  assign src.ov = sync_q[11:8];
  assign src.aux = sync_q[7:0];
endmodule : live_sync
`default_nettype wire

// [sim/input_fault_diag_status_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module input_fault_diag_status_tb;
  import diag_regs_pkg::*;

  logic clk; // Register clock
  logic srst; // Synchronous reset
  reg_addr_t reg_addr; // Port address
  logic reg_wr; // Write strobe
  reg_byte_t reg_wdata; // Write data
  logic reg_rd; // Read strobe
  logic [7:0] reg_rdata; // Read data
  logic reg_rd_valid; // Read data valid
  logic ch2_single_ended; // Channel 2 wiring
  logic ch2_ac_coupled; // Channel 2 coupling
  logic [7:0] ch2_fault_raw; // Channel-2 comparators
  logic [3:0] ov_raw; // Over-voltage comparators
  logic [7:0] aux_raw; // Monitor and bias sources
  logic ch1_scan_enable; // Scan outputs
  logic ch2_scan_enable;
  logic include_single_ended_neg;
  logic include_ac_coupled;
  int n_errors; // Mismatch count
  int cmp_count; // Comparison count

  input_fault_diag_status dut (
    .clk(clk),
    .srst(srst),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid),
    .ch2_single_ended(ch2_single_ended),
    .ch2_ac_coupled(ch2_ac_coupled),
    .ch2_fault_raw(ch2_fault_raw),
    .ov_raw(ov_raw),
    .aux_raw(aux_raw),
    .ch1_scan_enable(ch1_scan_enable),
    .ch2_scan_enable(ch2_scan_enable),
    .include_single_ended_neg(include_single_ended_neg),
    .include_ac_coupled(include_ac_coupled)
  );

  // Free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compare one value and count it
  task automatic check(input reg_byte_t seen, input reg_byte_t exp, input string msg);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // Print counts and verdict, then stop
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // Scan outputs packed into the low nibble
  function automatic reg_byte_t scan_out();
    return {4'h0, ch1_scan_enable, ch2_scan_enable, include_single_ended_neg, include_ac_coupled};
  endfunction : scan_out

  // One read strobe; data and valid are due exactly one cycle later
  task automatic rd(input reg_addr_t a, input reg_byte_t exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    check({7'h00, reg_rd_valid}, 8'h01, "read valid missing");
    check(reg_rdata, exp, "read data");
    @(negedge clk);
    check({7'h00, reg_rd_valid}, 8'h00, "read valid stuck");
  endtask : rd

  // One write strobe, then one cycle for the outputs to follow
  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask : wr

  // Let raw levels pass the two-stage synchroniser and the live register
  task automatic settle;
    repeat (4) @(negedge clk);
  endtask : settle

  // Reset values, unmapped address, read-only places
  task automatic t_reset_values;
    check(scan_out(), 8'h00, "scan outputs after reset");
    rd(CH2_LIVE_OFFSET, 8'h00);
    rd(OV_LIVE_OFFSET, 8'h00);
    rd(EVENT_LIVE_OFFSET, 8'h00);
    rd(SCAN_CFG_OFFSET, 8'h00);
    rd(BIAS_LATCHED_OFFSET, 8'h00);
    wr(8'h50, 8'hFF);
    rd(8'h50, 8'h00);
    wr(OV_LIVE_OFFSET, 8'hF0);
    rd(OV_LIVE_OFFSET, 8'h00);
  endtask : t_reset_values

  // Config bits: each alone, then all four together
  task automatic t_config;
    for (int i = 4; i < 8; i++)
    begin
      wr(SCAN_CFG_OFFSET, 8'h01 << i);
      check(scan_out(), 8'h01 << (i - 4), "scan output bit");
      rd(SCAN_CFG_OFFSET, 8'h01 << i);
    end
    wr(SCAN_CFG_OFFSET, 8'hF0);
    rd(SCAN_CFG_OFFSET, 8'hF0);
    check(scan_out(), 8'h0F, "all scan outputs");
  endtask : t_config

  // Each channel-2 fault bit alone, read-only, follows source
  task automatic t_ch2_walk;
    wr(SCAN_CFG_OFFSET, 8'h40);
    for (int i = 0; i < 8; i++)
    begin
      ch2_fault_raw = 8'h01 << i;
      settle();
      rd(CH2_LIVE_OFFSET, 8'h01 << i);
    end
    wr(CH2_LIVE_OFFSET, 8'h00);
    rd(CH2_LIVE_OFFSET, 8'h80);
    ch2_fault_raw = 8'h00;
    settle();
    rd(CH2_LIVE_OFFSET, 8'h00);
  endtask : t_ch2_walk

  // Over-voltage and event bits, plus repeated reads without side effect
  task automatic t_ov_aux;
    wr(SCAN_CFG_OFFSET, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      ov_raw = 4'h1 << i;
      settle();
      rd(OV_LIVE_OFFSET, {4'h1 << i, 4'h0});
    end
    ov_raw = 4'h0;
    for (int i = 0; i < 8; i++)
    begin
      aux_raw = 8'h01 << i;
      settle();
      rd(EVENT_LIVE_OFFSET, 8'h01 << i);
      rd(EVENT_LIVE_OFFSET, 8'h01 << i);
    end
    aux_raw = 8'h00;
    settle();
    rd(EVENT_LIVE_OFFSET, 8'h00);
    rd(OV_LIVE_OFFSET, 8'h00);
  endtask : t_ov_aux

  // A short bias fault pulse is held until read once
  task automatic t_latched;
    // Bias events left over from the event walk are returned once
    rd(BIAS_LATCHED_OFFSET, 8'h0F);
    aux_raw = 8'hF4;
    settle();
    aux_raw = 8'h00;
    settle();
    rd(EVENT_LIVE_OFFSET, 8'h00);
    rd(BIAS_LATCHED_OFFSET, 8'h04);
    rd(BIAS_LATCHED_OFFSET, 8'h00);
  endtask : t_latched

  // Scan enable, coupling and single-ended gating of the channel-2 bits
  task automatic t_gating;
    ch2_fault_raw = 8'hFF;
    wr(SCAN_CFG_OFFSET, 8'h00);
    settle();
    rd(CH2_LIVE_OFFSET, 8'h00);
    wr(SCAN_CFG_OFFSET, 8'h80);
    settle();
    rd(CH2_LIVE_OFFSET, 8'h00);
    ch2_ac_coupled = 1'b1;
    wr(SCAN_CFG_OFFSET, 8'h40);
    settle();
    rd(CH2_LIVE_OFFSET, 8'h00);
    wr(SCAN_CFG_OFFSET, 8'h50);
    settle();
    rd(CH2_LIVE_OFFSET, 8'hFF);
    ch2_ac_coupled = 1'b0;
    ch2_single_ended = 1'b1;
    wr(SCAN_CFG_OFFSET, 8'h40);
    settle();
    rd(CH2_LIVE_OFFSET, 8'hFF & ~CH2_NEG_PIN_MASK);
    wr(SCAN_CFG_OFFSET, 8'h60);
    settle();
    rd(CH2_LIVE_OFFSET, 8'hFF);
  endtask : t_gating

  // Reset in mid-run clears config; channel-2 then reads zero once its sources are low
  task automatic t_mid_reset;
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    check(scan_out(), 8'h00, "scan outputs after second reset");
    rd(SCAN_CFG_OFFSET, 8'h00);
    ch2_fault_raw = 8'h00;
    ch2_single_ended = 1'b0;
    settle();
    rd(CH2_LIVE_OFFSET, 8'h00);
  endtask : t_mid_reset

  // Watchdog cuts a hang short
  initial
  begin
    #200000;
    n_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    n_errors = 0;
    cmp_count = 0;
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    ch2_single_ended = 1'b0;
    ch2_ac_coupled = 1'b0;
    ch2_fault_raw = 8'h00;
    ov_raw = 4'h0;
    aux_raw = 8'h00;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    t_reset_values();
    t_config();
    t_ch2_walk();
    t_ov_aux();
    t_latched();
    t_gating();
    t_mid_reset();
    tally_and_finish();
  end
endmodule : input_fault_diag_status_tb
`default_nettype wire
